// >>> design/hexstr_pkg.sv
// Package with widths, codes and carrier types for the hex-to-ASCII datapath
package hexstr_pkg;

  localparam int WORD_W      = 16;
  localparam int NIBBLE_W    = 4;
  localparam int MAX_SRC_WDS = 4;
  localparam int MAX_DST_WDS = 8;
  localparam int ADDR_W      = 15;

  // ASCII bases for digits 0-9 and A-F
  localparam logic [7:0] ASCII_ZERO   = 8'h30;
  localparam logic [7:0] ASCII_UPPERA = 8'h41;
  localparam logic [3:0] DIGIT_TEN    = 4'hA;

  // Highest data memory word address
  localparam logic [ADDR_W-1:0] ADDR_TOP = 15'h7FFF;

  // Conversion widths
  typedef enum logic [1:0] {
    WIDTH_FOUR    = 2'h0,
    WIDTH_EIGHT   = 2'h1,
    WIDTH_SIXTEEN = 2'h2
  } conv_width_t;

  // Execution variant
  typedef enum logic {
    EXEC_EACH_CYCLE = 1'h0,
    EXEC_RISING     = 1'h1
  } exec_mode_t;

  // Instruction request
  typedef struct packed {
    logic               condition;
    conv_width_t        width;
    exec_mode_t         mode;
    logic [ADDR_W-1:0]  dstAddr;
  } conv_req_t;

  // Condition flags
  typedef struct packed {
    logic errorFlag;
    logic equalsFlag;
    logic negativeFlag;
  } cond_flags_t;

endpackage : hexstr_pkg

// >>> design/nibble_to_ascii.sv
// Single hexadecimal digit to ASCII code encoder
`timescale 1ns/1ps
module nibble_to_ascii (
  // Digit in
  input  wire logic [3:0] digit,
  // Character out
  output logic      [7:0] asciiChar
);

  // Uppercase letters for A-F, digits offset from zero character
  always_comb begin
    if (digit < hexstr_pkg::DIGIT_TEN) begin
      asciiChar = hexstr_pkg::ASCII_ZERO + {4'h0, digit};
    end else begin
      asciiChar = hexstr_pkg::ASCII_UPPERA + {4'h0, digit - hexstr_pkg::DIGIT_TEN};
    end
  end

endmodule : nibble_to_ascii

// >>> design/hex_to_ascii_converter.sv
// Datapath converting 16/32/64-bit operands to ASCII hexadecimal text
`timescale 1ns/1ps
module hex_to_ascii_converter #(
  parameter int WORD_W = hexstr_pkg::WORD_W,
  parameter int SRC_WDS = hexstr_pkg::MAX_SRC_WDS,
  parameter int DST_WDS = hexstr_pkg::MAX_DST_WDS
) (
  // Clock, reset, enable
  input  wire logic                                    core_clk,
  input  wire logic                                    rst,
  input  wire logic                                    clkEn,
  // Instruction request and source words (index 0 is S)
  input  wire hexstr_pkg::conv_req_t                   req,
  input  wire logic [SRC_WDS-1:0][WORD_W-1:0]          srcWords,
  // Destination write-back (index 0 is D)
  output logic                                         wrValid,
  output logic      [hexstr_pkg::ADDR_W-1:0]           wrAddr,
  output logic      [DST_WDS-1:0]                      wrMask,
  output logic      [DST_WDS-1:0][WORD_W-1:0]          wrWords,
  // Condition flags
  output hexstr_pkg::cond_flags_t                      flags,
  output logic                                         flagsValid
);

  // Digit count and operand width of the widest form
  localparam int DIGITS = SRC_WDS * WORD_W / hexstr_pkg::NIBBLE_W;
  localparam int VAL_W  = SRC_WDS * WORD_W;

  // Edge memory state
  logic                                   condPrev_reg;
  logic                                   condPrev_next;

  // Write-back state
  logic                                   wrValid_reg;
  logic                                   wrValid_next;
  logic [hexstr_pkg::ADDR_W-1:0]          wrAddr_reg;
  logic [hexstr_pkg::ADDR_W-1:0]          wrAddr_next;
  logic [DST_WDS-1:0]                     wrMask_reg;
  logic [DST_WDS-1:0]                     wrMask_next;
  logic [DST_WDS-1:0][WORD_W-1:0]         wrWords_reg;
  logic [DST_WDS-1:0][WORD_W-1:0]         wrWords_next;

  // Flag state
  hexstr_pkg::cond_flags_t                flags_reg;
  hexstr_pkg::cond_flags_t                flags_next;
  logic                                   flagsValid_reg;
  logic                                   flagsValid_next;

  // Combinational datapath
  logic                                   fire;
  logic [VAL_W-1:0]                       value;
  logic [VAL_W-1:0]                       aligned;
  logic [DIGITS-1:0][7:0]                 chars;
  logic [DIGITS-1:0][3:0]                 digitsMsbFirst;
  int                                     activeWds;
  logic [DST_WDS-1:0]                     useMask;
  logic [DST_WDS-1:0][WORD_W-1:0]         packedWords;

  // Higher-addressed source word is more significant
  always_comb begin
    value     = '0;
    activeWds = 1;
    case (req.width)
      hexstr_pkg::WIDTH_FOUR: begin
        // Source word S alone
        value     = {{(VAL_W-WORD_W){1'h0}}, srcWords[0]};
        activeWds = 1;
      end
      hexstr_pkg::WIDTH_EIGHT: begin
        // S+1 above S
        value     = {{(VAL_W-2*WORD_W){1'h0}}, srcWords[1], srcWords[0]};
        activeWds = 2;
      end
      hexstr_pkg::WIDTH_SIXTEEN: begin
        // S+3 down to S
        value     = {srcWords[3], srcWords[2], srcWords[1], srcWords[0]};
        activeWds = 4;
      end
      default: begin
        // Unused width code: zero operand in the four-char layout
        value     = '0;
        activeWds = 1;
      end
    endcase
  end

  // Left-justify so digit 0 is always the leading digit of the operand
  // One fixed packing network then serves every width, at the cost of a wide shifter
  always_comb begin
    aligned = value << (VAL_W - activeWds * WORD_W);
  end

  // Split into nibbles, leading digit at index 0
  // Digits past the operand are zero and never reach a written word
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : gDigit
      assign digitsMsbFirst[g] = aligned[VAL_W-1-g*4 -: 4];
      nibble_to_ascii uEnc (
        .digit     (digitsMsbFirst[g]),
        .asciiChar (chars[g])
      );
    end
  endgenerate

  // Word w of the destination is written only when the operand reaches it
  // Narrow forms leave the words beyond their text untouched in memory
  always_comb begin
    useMask = '0;
    for (int w = 0; w < DST_WDS; w++) begin
      useMask[w] = (w < 2 * activeWds);
    end
  end

  // Two characters per word, leading character in the upper byte
  generate
    for (g = 0; g < DST_WDS; g++) begin : gPack
      assign packedWords[g] = {chars[2*g], chars[2*g+1]};
    end
  endgenerate

  // Edge memory follows the condition in both variants, so a change of
  // variant never meets a stale level
  always_comb begin
    condPrev_next = req.condition;
  end

  // Each-cycle variant fires on level, rising variant on a fresh edge
  always_comb begin
    if (req.mode == hexstr_pkg::EXEC_RISING) begin
      fire = req.condition && !condPrev_reg;
    end else begin
      fire = req.condition;
    end
  end

  // Edge memory register; reset clears it, so a level held through reset
  // counts as a rising edge on the first enabled cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      condPrev_reg <= 1'h0;
    end else if (clkEn) begin
      condPrev_reg <= condPrev_next;
    end
  end

  // Write-back next state; idle cycles keep the last words for the reader
  always_comb begin
    wrValid_next = fire;
    wrAddr_next  = wrAddr_reg;
    wrMask_next  = wrMask_reg;
    wrWords_next = wrWords_reg;
    if (fire) begin
      wrAddr_next = req.dstAddr;  // Range is the caller's duty
      wrMask_next = useMask;
      // Unused words cleared so no stale text rides along
      for (int w = 0; w < DST_WDS; w++) begin
        wrWords_next[w] = useMask[w] ? packedWords[w] : '0;
      end
    end
  end

  // Write-back registers; a low enable also holds the valid pulse,
  // so the reader still sees it once the enable returns
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrValid_reg <= 1'h0;
      wrAddr_reg  <= '0;
      wrMask_reg  <= '0;
      wrWords_reg <= '0;
    end else if (clkEn) begin
      wrValid_reg <= wrValid_next;
      wrAddr_reg  <= wrAddr_next;
      wrMask_reg  <= wrMask_next;
      wrWords_reg <= wrWords_next;
    end
  end

  // Flag next state, computed in the same step as the words
  always_comb begin
    flagsValid_next = fire;
    flags_next      = flags_reg;
    if (fire) begin
      flags_next.errorFlag    = 1'h0;  // every operand converts
      flags_next.equalsFlag   = (value == '0);
      // Leading bit of the operand, not of the widest form
      flags_next.negativeFlag = aligned[VAL_W-1];
    end
  end

  // Flag registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_reg      <= '0;
      flagsValid_reg <= 1'h0;
    end else if (clkEn) begin
      flags_reg      <= flags_next;
      flagsValid_reg <= flagsValid_next;
    end
  end

  // Outputs straight from flops
  // No logic after the registers, so the memory port sees clean timing
  assign wrValid    = wrValid_reg;
  assign wrAddr     = wrAddr_reg;
  assign wrMask     = wrMask_reg;
  assign wrWords    = wrWords_reg;
  assign flags      = flags_reg;
  assign flagsValid = flagsValid_reg;

endmodule : hex_to_ascii_converter

// >>> verification/hex_to_ascii_converter_monitor.sv
// Port checker for the hex-to-ASCII converter
`timescale 1ns/1ps
module hex_to_ascii_converter_monitor #(
  parameter int WORD_W  = 16,
  parameter int SRC_WDS = 4,
  parameter int DST_WDS = 8
) (
  // Clock, reset, request
  input wire logic                           core_clk,
  input wire logic                           rst,
  input wire logic                           clkEn,
  input wire hexstr_pkg::conv_req_t          req,
  input wire logic [SRC_WDS-1:0][WORD_W-1:0] srcWords,
  // Results
  input wire logic                           wrValid,
  input wire logic [hexstr_pkg::ADDR_W-1:0]  wrAddr,
  input wire logic [DST_WDS-1:0]             wrMask,
  input wire logic [DST_WDS-1:0][WORD_W-1:0] wrWords,
  input wire hexstr_pkg::cond_flags_t        flags,
  input wire logic                           flagsValid
);
  logic condSeen_reg;
  logic take;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Edge memory, cleared by reset so a held condition counts as rising
  always_ff @(posedge core_clk) begin
    if (rst) condSeen_reg <= 1'h0;
    else if (clkEn) condSeen_reg <= req.condition;
  end
  // Edge at which a request is taken
  assign take = clkEn && req.condition && (req.mode == hexstr_pkg::EXEC_EACH_CYCLE || !condSeen_reg);
  a_take_pulse: assert property (take |=> wrValid && flagsValid)
    else $error("no result after a taken request");
  a_no_extra: assert property (clkEn && !take |=> !wrValid)
    else $error("result without a taken request");
  a_error_off: assert property (flagsValid |-> !flags.errorFlag)
    else $error("error flag set after conversion");
  a_four_mask: assert property (take && req.width == hexstr_pkg::WIDTH_FOUR |=> wrMask == 8'h03)
    else $error("four-char mask wrong");
  a_eight_mask: assert property (take && req.width == hexstr_pkg::WIDTH_EIGHT |=> wrMask == 8'h0F)
    else $error("eight-char mask wrong");
  a_sixteen_mask: assert property (take && req.width == hexstr_pkg::WIDTH_SIXTEEN |=> wrMask == 8'hFF)
    else $error("sixteen-char mask wrong");
  a_equals_zero: assert property (take && req.width == hexstr_pkg::WIDTH_FOUR
    |=> flags.equalsFlag == ($past(srcWords[0]) == 16'h0))
    else $error("equals flag wrong");
  a_neg_msb: assert property (take && req.width == hexstr_pkg::WIDTH_SIXTEEN
    |=> flags.negativeFlag == $past(srcWords[3][15]))
    else $error("negative flag wrong");
  a_addr_follow: assert property (take |=> wrAddr == $past(req.dstAddr))
    else $error("destination address wrong");
endmodule : hex_to_ascii_converter_monitor

bind hex_to_ascii_converter hex_to_ascii_converter_monitor #(.WORD_W(WORD_W), .SRC_WDS(SRC_WDS), .DST_WDS(DST_WDS))
  i_mon (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .req(req), .srcWords(srcWords), .wrValid(wrValid),
  .wrAddr(wrAddr), .wrMask(wrMask), .wrWords(wrWords), .flags(flags), .flagsValid(flagsValid));

// >>> verification/hex_to_ascii_converter_tb_top.sv
// Self-checking bench for the hex-to-ASCII converter
`timescale 1ns/1ps
module hex_to_ascii_converter_tb_top;
  logic                    core_clk;
  logic                    rst;
  logic                    clkEn;
  hexstr_pkg::conv_req_t   req;
  logic [3:0][15:0]        srcWords;
  logic                    wrValid;
  logic                    flagsValid;
  logic [14:0]             wrAddr;
  logic [7:0]              wrMask;
  logic [7:0][15:0]        wrWords;
  hexstr_pkg::cond_flags_t flags;
  int                      fail_count = 0;
  int                      cmp_count = 0;
  logic [31:0]             seed = 32'h1D;
  hex_to_ascii_converter i_dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .req(req), .srcWords(srcWords),
    .wrValid(wrValid), .wrAddr(wrAddr), .wrMask(wrMask), .wrWords(wrWords), .flags(flags), .flagsValid(flagsValid));
  // 25 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  // Xorshift source, repeatable from its fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Expected character for one digit
  function automatic logic [7:0] hx(logic [3:0] d);
    return (d < 4'hA) ? 8'h30 + d : 8'h41 + d - 8'h0A;
  endfunction : hx
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // One conversion; high source words carry junk for the short forms
  task automatic conv(int w, logic [63:0] v);
    int nd;
    int n;
    logic [63:0] m;
    logic [63:0] x;
    nd = (w == 3) ? 4 : 4 << w;
    n = 0;
    m = (64'h1 << (nd * 4)) - 64'h1;
    // Unused width code converts a zero operand
    x = (w == 3) ? 64'h0 : v;
    @(negedge core_clk);
    req.condition = 1'h1;
    req.width = hexstr_pkg::conv_width_t'(w);
    req.dstAddr = 15'(rnd() % (32769 - nd / 2));
    srcWords = v;
    @(negedge core_clk);
    req.condition = 1'h0;
    while (wrValid !== 1'h1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    if (wrValid !== 1'h1) begin
      fail_count++;
      print_verdict();
    end
    chk("mask", (16'h1 << (nd / 2)) - 16'h1, 16'(wrMask));
    for (int i = 0; i < nd / 2; i++)
      chk("word", {hx(x[(nd-1-2*i)*4 +: 4]), hx(x[(nd-2-2*i)*4 +: 4])}, wrWords[i]);
    for (int i = nd / 2; i < 8; i++)
      chk("spare", 16'h0, wrWords[i]);
    chk("flags", {13'h0, 1'h0, (x & m) == 64'h0, x[nd*4-1]}, 16'(flags));
    chk("fvalid", 16'h1, 16'(flagsValid));
    chk("addr", 16'(req.dstAddr), 16'(wrAddr));
  endtask : conv
  // Hold the condition over three edges and count result pulses
  task automatic hold(logic md, int exp);
    int n;
    n = 0;
    @(negedge core_clk);
    req.mode = hexstr_pkg::exec_mode_t'(md);
    req.condition = 1'h1;
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      if (wrValid === 1'h1) n++;
      if (i == 2) req.condition = 1'h0;
    end
    chk("pulses", 16'(exp), 16'(n));
  endtask : hold
  // Main sequence: corner values, then random ones, for every width
  initial begin
    rst = 1'h1;
    clkEn = 1'h1;
    req = '0;
    srcWords = '0;
    repeat (16) @(negedge core_clk);
    rst = 1'h0;
    for (int w = 0; w < 3; w++) begin
      conv(w, 64'h0);
      conv(w, '1);
      conv(w, 64'h1234567890ABCDEF);
      repeat (6) conv(w, {rnd(), rnd()});
    end
    conv(3, '1);
    hold(1'h0, 3);
    hold(1'h1, 1);
    // Enable low: the held request waits, then counts as one fresh edge
    @(negedge core_clk);
    clkEn = 1'h0;
    req.condition = 1'h1;
    repeat (3) @(negedge core_clk);
    chk("frozen", 16'h0, 16'(wrValid));
    clkEn = 1'h1;
    @(negedge core_clk);
    chk("thawed", 16'h1, 16'(wrValid));
    req.condition = 1'h0;
    // Reset in mid-run with the condition held high
    @(negedge core_clk);
    rst = 1'h1;
    req.condition = 1'h1;
    repeat (2) @(negedge core_clk);
    chk("rstmask", 16'h0, 16'(wrMask));
    chk("rstflags", 16'h0, 16'(flags));
    rst = 1'h0;
    @(negedge core_clk);
    chk("rearm", 16'h1, 16'(wrValid));
    req.condition = 1'h0;
    print_verdict();
  end
endmodule : hex_to_ascii_converter_tb_top
